// [design/short_detect_defs.vh]
// constants for the output short detector: register map, fields, resets
// assumes a 32-bit apb slave on pclk and three complementary output pairs
`ifndef SHORT_DETECT_DEFS_VH
`define SHORT_DETECT_DEFS_VH

// register byte addresses
`define ADDR_CTRL_STATUS   12'h000
`define ADDR_EVT_STATUS    12'h004
`define ADDR_EVT_MASK      12'h008
`define ADDR_POLARITY      12'h00c
`define ADDR_STATE         12'h010

// control/status fields
`define BIT_SHORT_FLAG     15
`define BIT_HIZ_ENABLE     9
`define BIT_IRQ_ENABLE     8
`define CTRL_RESET         16'h0000

// event status / mask fields
`define EVT_WIDTH          3
`define EVT_SHORT          0
`define EVT_LOCKED_WRITE   1
`define EVT_BAD_CLEAR      2
`define EVT_RESET          3'h0

// state register fields
`define BIT_STATE_LOCKED   0
`define BIT_STATE_ARMED    1
`define STATE_PAIR_LSB     2

// active level of each phase, 1 = active high
`define POLARITY_RESET     6'h3f

`endif

// [design/pair_short_monitor.v]
// per-pair comparator: flags pairs whose two phases are both active
// assumes phase inputs synchronous to pclk; result registered once
`timescale 1ns/100ps
module pair_short_monitor #(
  parameter PAIRS = 3
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // phases and active levels
  input  wire [PAIRS-1:0] phase_p,
  input  wire [PAIRS-1:0] phase_n,
  input  wire [PAIRS-1:0] level_p,
  input  wire [PAIRS-1:0] level_n,
  // results
  output reg  [PAIRS-1:0] pair_short_ff,
  output reg              any_short_ff
);

  wire [PAIRS-1:0] nxt_pair_short;

  genvar i;
  generate
    for (i = 0; i < PAIRS; i = i + 1) begin : g_pair
      assign nxt_pair_short[i] = (phase_p[i] == level_p[i]) && (phase_n[i] == level_n[i]);
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_short_ff <= {PAIRS{1'b0}};
      any_short_ff  <= 1'b0;
    end else begin
      pair_short_ff <= nxt_pair_short;
      any_short_ff  <= |nxt_pair_short;
    end
  end

endmodule // pair_short_monitor

// [design/output_short_detect_control.v]
// output short detector with apb register access and pin high-impedance control
// assumes timer phases synchronous to pclk; apb master per amba apb3
`timescale 1ns/100ps
`include "short_detect_defs.vh"
module output_short_detect_control #(
  parameter PAIRS = 3
) (
  // clock and reset
  input  wire               pclk,
  input  wire               presetn,
  // apb slave
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [11:0]        paddr,
  input  wire [31:0]        pwdata,
  output reg  [31:0]        prdata_ff,
  output reg                pready_ff,
  output reg                pslverr_ff,
  // timer phases in
  input  wire [PAIRS-1:0]   phase_p,
  input  wire [PAIRS-1:0]   phase_n,
  // output pins
  output reg  [PAIRS-1:0]   pin_p_ff,
  output reg  [PAIRS-1:0]   pin_n_ff,
  output reg  [2*PAIRS-1:0] pin_oe_ff,
  // interrupt
  output reg                irq_ff
);

  localparam EVW = `EVT_WIDTH;

  // stored state
  reg              short_flag_ff;
  reg              hiz_en_ff;
  reg              irq_en_ff;
  reg              hiz_locked_ff;
  reg              clear_armed_ff;
  reg  [EVW-1:0]   evt_status_ff;
  reg  [EVW-1:0]   evt_mask_ff;
  reg  [2*PAIRS-1:0] polarity_ff;
  reg              hiz_ff;

  // next values
  reg              nxt_short_flag;
  reg              nxt_hiz_en;
  reg              nxt_irq_en;
  reg              nxt_hiz_locked;
  reg              nxt_clear_armed;
  reg  [EVW-1:0]   nxt_evt_status;
  reg  [EVW-1:0]   nxt_evt_mask;
  reg  [2*PAIRS-1:0] nxt_polarity;
  reg  [31:0]      nxt_prdata;
  reg              nxt_slverr;

  // monitor results
  wire [PAIRS-1:0] pair_short;
  wire             any_short;

  // bus decode
  wire setup_phase  = psel & ~penable;
  wire access_done  = psel & penable & pready_ff;
  wire wr_done      = access_done & pwrite;
  wire rd_done      = access_done & ~pwrite;
  wire sel_ctrl     = (paddr == `ADDR_CTRL_STATUS);
  wire sel_evt      = (paddr == `ADDR_EVT_STATUS);
  wire sel_mask     = (paddr == `ADDR_EVT_MASK);
  wire sel_pol      = (paddr == `ADDR_POLARITY);
  wire sel_state    = (paddr == `ADDR_STATE);
  wire sel_any      = sel_ctrl | sel_evt | sel_mask | sel_pol | sel_state;
  wire wr_ctrl      = wr_done & sel_ctrl;

  pair_short_monitor #(
    .PAIRS (PAIRS)
  ) u_monitor (
    .pclk          (pclk),
    .presetn       (presetn),
    .phase_p       (phase_p),
    .phase_n       (phase_n),
    .level_p       (polarity_ff[PAIRS-1:0]),
    .level_n       (polarity_ff[2*PAIRS-1:PAIRS]),
    .pair_short_ff (pair_short),
    .any_short_ff  (any_short)
  );

  // control/status image, reserved bits zero
  reg [15:0] ctrl_image;
  always @* begin
    ctrl_image = `CTRL_RESET;
    ctrl_image[`BIT_SHORT_FLAG] = short_flag_ff;
    ctrl_image[`BIT_HIZ_ENABLE] = hiz_en_ff;
    ctrl_image[`BIT_IRQ_ENABLE] = irq_en_ff;
  end

  // read data, prepared in the setup cycle
  always @* begin
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = 1'b0;
    if (setup_phase) begin
      if (!sel_any) begin
        nxt_slverr = 1'b1;
      end else if (!pwrite) begin
        if (sel_ctrl) begin
          nxt_prdata[15:0] = ctrl_image;
        end
        if (sel_evt) begin
          nxt_prdata[EVW-1:0] = evt_status_ff;
        end
        if (sel_mask) begin
          nxt_prdata[EVW-1:0] = evt_mask_ff;
        end
        if (sel_pol) begin
          nxt_prdata[2*PAIRS-1:0] = polarity_ff;
        end
        if (sel_state) begin
          nxt_prdata[`BIT_STATE_LOCKED] = hiz_locked_ff;
          nxt_prdata[`BIT_STATE_ARMED]  = clear_armed_ff;
          nxt_prdata[`STATE_PAIR_LSB +: PAIRS] = pair_short;
        end
      end
    end
  end

  // flag, enables, clear sequence
  always @* begin
    nxt_short_flag  = short_flag_ff;
    nxt_hiz_en      = hiz_en_ff;
    nxt_irq_en      = irq_en_ff;
    nxt_hiz_locked  = hiz_locked_ff;
    nxt_clear_armed = clear_armed_ff;
    if (rd_done && sel_ctrl && prdata_ff[`BIT_SHORT_FLAG]) begin
      nxt_clear_armed = 1'b1;
    end
    if (wr_ctrl) begin
      nxt_irq_en = pwdata[`BIT_IRQ_ENABLE];
      if (!hiz_locked_ff) begin
        nxt_hiz_en     = pwdata[`BIT_HIZ_ENABLE];
        nxt_hiz_locked = 1'b1;
      end
      if (!pwdata[`BIT_SHORT_FLAG] && clear_armed_ff) begin
        nxt_short_flag  = 1'b0;
        nxt_clear_armed = 1'b0;
      end
    end
    if (any_short) begin
      nxt_short_flag = 1'b1;
    end
    if (!nxt_short_flag) begin
      nxt_clear_armed = 1'b0;
    end
  end

  // sticky events, write one to clear, set wins
  always @* begin
    nxt_evt_status = evt_status_ff;
    nxt_evt_mask   = evt_mask_ff;
    nxt_polarity   = polarity_ff;
    if (wr_done && sel_evt) begin
      nxt_evt_status = evt_status_ff & ~pwdata[EVW-1:0];
    end
    if (wr_done && sel_mask) begin
      nxt_evt_mask = pwdata[EVW-1:0];
    end
    if (wr_done && sel_pol) begin
      nxt_polarity = pwdata[2*PAIRS-1:0];
    end
    if (any_short && !short_flag_ff) begin
      nxt_evt_status[`EVT_SHORT] = 1'b1;
    end
    if (wr_ctrl && hiz_locked_ff && (pwdata[`BIT_HIZ_ENABLE] != hiz_en_ff)) begin
      nxt_evt_status[`EVT_LOCKED_WRITE] = 1'b1;
    end
    if (wr_ctrl && !pwdata[`BIT_SHORT_FLAG] && short_flag_ff && !clear_armed_ff) begin
      nxt_evt_status[`EVT_BAD_CLEAR] = 1'b1;
    end
  end

  // registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_flag_ff  <= 1'b0;
      hiz_en_ff      <= 1'b0;
      irq_en_ff      <= 1'b0;
      hiz_locked_ff  <= 1'b0;
      clear_armed_ff <= 1'b0;
      evt_status_ff  <= `EVT_RESET;
      evt_mask_ff    <= `EVT_RESET;
      polarity_ff    <= `POLARITY_RESET;
      prdata_ff      <= 32'h0000_0000;
      pready_ff      <= 1'b0;
      pslverr_ff     <= 1'b0;
    end else begin
      short_flag_ff  <= nxt_short_flag;
      hiz_en_ff      <= nxt_hiz_en;
      irq_en_ff      <= nxt_irq_en;
      hiz_locked_ff  <= nxt_hiz_locked;
      clear_armed_ff <= nxt_clear_armed;
      evt_status_ff  <= nxt_evt_status;
      evt_mask_ff    <= nxt_evt_mask;
      polarity_ff    <= nxt_polarity;
      // one wait-free access cycle after each setup
      pready_ff      <= setup_phase;
      pslverr_ff     <= nxt_slverr;
      prdata_ff      <= nxt_prdata;
    end
  end

  // pin drive and interrupt
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hiz_ff    <= 1'b0;
      pin_p_ff  <= {PAIRS{1'b0}};
      pin_n_ff  <= {PAIRS{1'b0}};
      pin_oe_ff <= {2*PAIRS{1'b0}};
      irq_ff    <= 1'b0;
    end else begin
      hiz_ff    <= nxt_short_flag & nxt_hiz_en;
      pin_p_ff  <= phase_p;
      pin_n_ff  <= phase_n;
      pin_oe_ff <= {2*PAIRS{~(nxt_short_flag & nxt_hiz_en)}};
      irq_ff    <= (nxt_short_flag & nxt_irq_en) | (|(nxt_evt_status & nxt_evt_mask));
    end
  end

endmodule // output_short_detect_control

// [bench/short_detect_chk.sv]
// port checker for the output short detector
// assumes default polarity, all phases active high
`timescale 1ns/100ps
module short_detect_chk #(parameter PAIRS = 3) (
  // clock and reset
  input wire               pclk, presetn,
  // apb
  input wire               psel, penable, pwrite,
  input wire [11:0]        paddr,
  input wire [31:0]        prdata_ff,
  input wire               pready_ff, pslverr_ff,
  // pins
  input wire [PAIRS-1:0]   phase_p, phase_n,
  input wire [2*PAIRS-1:0] pin_oe_ff,
  input wire               irq_ff
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel & penable & pwrite;
  wire sh = |(phase_p & phase_n);
  AST_READY: assert property (psel && !penable |=> pready_ff) else $error("no ready");
  AST_READY_CAUSE: assert property (pready_ff |-> $past(psel && !penable)) else $error("stray ready");
  AST_RSVD: assert property (psel && penable && pready_ff && !pwrite && paddr == 12'h000
    |-> prdata_ff[31:16] == 16'h0000 && prdata_ff[14:10] == 5'h00 && prdata_ff[7:0] == 8'h00) else $error("reserved set");
  AST_OE_UNIFORM: assert property (!(|pin_oe_ff) || &pin_oe_ff) else $error("mixed oe");
  AST_HIZ_CAUSE: assert property ($fell(pin_oe_ff[0]) |-> $past(sh, 2) || $past(wr) || $past(wr, 2))
    else $error("hiz without short");
  AST_HIZ_HOLD: assert property ($rose(pin_oe_ff[0]) |-> !$past(presetn, 2) || $past(wr) || $past(wr, 2))
    else $error("hiz dropped");
  AST_IRQ_RISE: assert property ($rose(irq_ff) |-> $past(sh, 2) || $past(wr) || $past(wr, 2))
    else $error("irq without cause");
  AST_IRQ_FALL: assert property ($fell(irq_ff) |-> $past(wr) || $past(wr, 2)) else $error("irq dropped");
  AST_SLVERR: assert property (pslverr_ff |-> pready_ff && prdata_ff == 32'h00000000) else $error("bad slverr");
  cover property ($fell(pin_oe_ff[0]));
  cover property ($rose(irq_ff));
  cover property (pslverr_ff);
endmodule // short_detect_chk
bind output_short_detect_control short_detect_chk #(.PAIRS(PAIRS)) chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
  .pslverr_ff(pslverr_ff), .phase_p(phase_p), .phase_n(phase_n), .pin_oe_ff(pin_oe_ff), .irq_ff(irq_ff));

// [bench/phase_source.sv]
// timer side model: three complementary phase pairs
// assumes active high phases; short_req forces a pair both active
`timescale 1ns/100ps
module phase_source (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // control
  input  wire [2:0] short_req,
  // phases
  output reg  [2:0] phase_p,
  output reg  [2:0] phase_n
);
  reg [2:0] cnt_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= 3'h0;
      phase_p <= 3'h0;
      phase_n <= 3'h0;
    end else begin
      cnt_ff  <= cnt_ff + 3'h1;
      phase_p <= cnt_ff | short_req;
      phase_n <= ~cnt_ff | short_req;
    end
  end
endmodule // phase_source

// [bench/test_output_short_detect_control.sv]
// testbench for the output short detector
// assumes phase_source on the timer side; apb driven here
`timescale 1ns/100ps
`include "short_detect_defs.vh"
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin mismatches = mismatches + 1; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module test_output_short_detect_control;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h00000000;
  reg  [2:0]  short_req = 3'h0;
  reg  [32:0] e;
  reg  [32:0] expq[$];
  wire [31:0] prdata_ff;
  wire        pready_ff, pslverr_ff, irq_ff;
  wire [2:0]  phase_p, phase_n, pin_p_ff, pin_n_ff;
  wire [5:0]  pin_oe_ff;
  integer     mismatches = 0, checks = 0, seed = 96838, k;
  reg  [5:0]  ph_d = 6'h00;
  reg         rst_d = 1'b0;
  always #25 pclk = ~pclk;
  phase_source model (.pclk(pclk), .presetn(presetn), .short_req(short_req), .phase_p(phase_p), .phase_n(phase_n));
  output_short_detect_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .phase_p(phase_p), .phase_n(phase_n), .pin_p_ff(pin_p_ff), .pin_n_ff(pin_n_ff),
    .pin_oe_ff(pin_oe_ff), .irq_ff(irq_ff));
  // read results against the oldest note
  always @(posedge pclk) begin
    if (psel & penable & pready_ff & ~pwrite) begin
      e = expq.pop_front();
      `CHK({pslverr_ff, prdata_ff}, e)
    end
    // pins copy the phases one cycle late
    if (rst_d && presetn) begin
      `CHK({pin_n_ff, pin_p_ff}, ph_d)
    end
    ph_d  <= {phase_n, phase_p};
    rst_d <= presetn;
  end
  // one transfer, left selected so the next setup may follow
  task apb(input w, input [11:0] a, input [31:0] d, input [32:0] x);
    begin
      if (!w) expq.push_back(x);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready_ff !== 1'b1) @(posedge pclk);
    end
  endtask
  task idle;
    begin
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
  task shortp;
    begin
      k = {$random(seed)} % 3;
      short_req <= 3'h1 << k;
      @(posedge pclk);
      short_req <= 3'h0;
      repeat (4) @(posedge pclk);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (2000) @(posedge pclk);
    mismatches = mismatches + 1;
    test_done;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `ADDR_CTRL_STATUS, 32'h0, 33'h0);
    apb(1, `ADDR_CTRL_STATUS, 32'h0300, 33'h0);
    apb(1, `ADDR_CTRL_STATUS, 32'h0000, 33'h0);
    apb(0, `ADDR_CTRL_STATUS, 32'h0, 33'h0200);
    apb(1, `ADDR_CTRL_STATUS, 32'h0100, 33'h0);
    apb(0, `ADDR_CTRL_STATUS, 32'h0, 33'h0300);
    apb(0, 12'h020, 32'h0, 33'h100000000);
    idle;
    $display("registers done");
    shortp;
    `CHK(irq_ff, 1'b1)
    `CHK(pin_oe_ff, 6'h00)
    apb(1, `ADDR_CTRL_STATUS, 32'h0300, 33'h0);
    apb(0, `ADDR_CTRL_STATUS, 32'h0, 33'h8300);
    `CHK(pin_oe_ff, 6'h00)
    apb(1, `ADDR_CTRL_STATUS, 32'h0300, 33'h0);
    apb(0, `ADDR_CTRL_STATUS, 32'h0, 33'h0300);
    idle;
    `CHK(irq_ff, 1'b0)
    `CHK(pin_oe_ff, 6'h3f)
    $display("clear done");
    apb(0, `ADDR_EVT_STATUS, 32'h0, 33'h7);
    apb(1, `ADDR_EVT_MASK, 32'h1, 33'h0);
    idle;
    `CHK(irq_ff, 1'b1)
    apb(1, `ADDR_EVT_STATUS, 32'h7, 33'h0);
    apb(0, `ADDR_EVT_STATUS, 32'h0, 33'h0);
    apb(1, `ADDR_EVT_MASK, 32'h0, 33'h0);
    apb(1, `ADDR_CTRL_STATUS, 32'h0000, 33'h0);
    idle;
    `CHK(irq_ff, 1'b0)
    $display("events done");
    shortp;
    `CHK(irq_ff, 1'b0)
    `CHK(pin_oe_ff, 6'h00)
    apb(0, `ADDR_CTRL_STATUS, 32'h0, 33'h8200);
    idle;
    $display("second short done");
    // mid-run reset: enable write accepted once more
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `ADDR_CTRL_STATUS, 32'h0, 33'h0);
    apb(1, `ADDR_CTRL_STATUS, 32'h0200, 33'h0);
    apb(0, `ADDR_CTRL_STATUS, 32'h0, 33'h0200);
    // phase_n active low makes the model's pairs short
    apb(1, `ADDR_POLARITY, 32'h7, 33'h0);
    apb(1, `ADDR_CTRL_STATUS, 32'h0300, 33'h0);
    apb(0, `ADDR_POLARITY, 32'h0, 33'h7);
    idle;
    `CHK(irq_ff, 1'b1)
    `CHK(pin_oe_ff, 6'h00)
    $display("reset and polarity done");
    test_done;
  end
endmodule // test_output_short_detect_control
